// ===== tmw_pkg.sv
// Constants and carrier types for the 8-bit timer with waveform generator
package tmw_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_CMPA = 8'h08;
	localparam logic [7:0] ADDR_CMPB = 8'h0c;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// Control register field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_COMB_LSB = 4;
	localparam int CTRL_COMA_LSB = 6;
	localparam int CTRL_DIRA_BIT = 8;
	localparam int CTRL_DIRB_BIT = 9;
	localparam int CTRL_RUN_BIT = 10;
	localparam int CTRL_DIV_LSB = 16;

	// Flag register bit positions
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_MATCHA_BIT = 1;
	localparam int FLAG_MATCHB_BIT = 2;

	// Wave mode selection codes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
	localparam logic [2:0] MODE_PWM_MAXTOP = 3'h3;
	localparam logic [2:0] MODE_PWM_CMPTOP = 3'h7;

	// Counter extremes and bus answers
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} tmw_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tmw_axi_rsp_type;

	typedef struct packed {
		logic [2:0] waveModeSel;
		logic [1:0] compareOutModeA;
		logic [1:0] compareOutModeB;
		logic dirA;
		logic dirB;
		logic run;
		logic [7:0] tickDiv;
		logic [7:0] divCnt;
		logic [7:0] countValue;
		logic [7:0] compareBufA;
		logic [7:0] compareBufB;
		logic [7:0] compareValueA;
		logic [7:0] compareValueB;
		logic overflowFlag;
		logic matchFlagA;
		logic matchFlagB;
		logic waveA;
		logic waveB;
		logic matchBlock;
		logic awHave;
		logic [7:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tmw_state_type;

	localparam tmw_state_type STATE_RESET = '0;

endpackage

// ===== tmw_timer.sv
// 8-bit timer/counter with waveform generator and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Only the wave mode selection decides how the counter counts.
// - Normal mode always increments, never clears on match, wraps 0xFF to 0x00.
// - Normal mode sets overflow as count becomes zero; hardware never clears it.
// - Normal mode accepts a count write at any moment.
// - Clear-on-match mode clears the count after it equals compare value A.
// - Clear-on-match compare A is written directly; missed match wraps through 0xFF.
// - Clear-on-match sets match flag A each time the top is reached.
// - Clear-on-match with output mode 1 toggles output A on each match.
// - Compare output reaches the pin only when its direction bit is output.
// - Clear-on-match still sets overflow when count passes 0xFF to 0x00.
// - Fast PWM is mode 3 (top 0xFF) or mode 7 (top compare A).
// - Fast PWM counts up to top, then returns to zero next tick.
// - Fast PWM output mode 2 is non-inverted, mode 3 inverted.
// - Fast PWM sets overflow every time the count leaves top for zero.
// - Fast PWM output mode 1 toggles A only with high mode bit; B never.
// - Fast PWM mode 3 with compare A at bottom gives a one-tick spike each period.
// - Fast PWM compare A at max holds output constant per polarity.
// - Fast PWM compare values are double-buffered, loaded at period end.
// - Output mode zero leaves the internal output state untouched.
// - Match flags set at the tick after equality; software writes one to clear.
// - A count write blocks every match in the next tick, even when stopped.
module tmw_timer (
	input wire logic core_clk,
	input wire logic reset,
	input wire tmw_pkg::tmw_axi_req_type axiReq,
	output var tmw_pkg::tmw_axi_rsp_type axiRsp,
	output logic waveOutA,
	output logic waveOutAOeN,
	output logic waveOutB,
	output logic waveOutBOeN
);
	import tmw_pkg::*;

	// Registered state and its next value
	tmw_state_type q;
	tmw_state_type d;

	// Mode decode
	logic isClear;
	logic isPwm;
	logic [7:0] topValue;

	// Tick enable and compare events
	logic tick;
	logic matchA;
	logic matchB;

	// Period end in PWM
	logic atTop;
	logic wrap;

	// Write path under byte strobes
	logic doWrite;
	logic [31:0] byteMask;
	logic [31:0] oldWord;
	logic [31:0] newWord;
	logic [31:0] clrBits;

	// Register readback for any offset; unmapped reads give zero
	function automatic logic [31:0] readWord(input tmw_state_type s,
		input logic [7:0] addr);
		logic [31:0] v;
		v = '0;
		unique case (addr)
			ADDR_CTRL: begin
				v[CTRL_MODE_LSB +: 3] = s.waveModeSel;
				v[CTRL_COMB_LSB +: 2] = s.compareOutModeB;
				v[CTRL_COMA_LSB +: 2] = s.compareOutModeA;
				v[CTRL_DIRA_BIT] = s.dirA;
				v[CTRL_DIRB_BIT] = s.dirB;
				v[CTRL_RUN_BIT] = s.run;
				v[CTRL_DIV_LSB +: 8] = s.tickDiv;
			end
			ADDR_COUNT: v[7:0] = s.countValue;
			// Buffers read back, so software sees what it wrote
			ADDR_CMPA: v[7:0] = s.compareBufA;
			ADDR_CMPB: v[7:0] = s.compareBufB;
			// Write-one-to-clear flags read back as levels
			ADDR_FLAGS: begin
				v[FLAG_OVF_BIT] = s.overflowFlag;
				v[FLAG_MATCHA_BIT] = s.matchFlagA;
				v[FLAG_MATCHB_BIT] = s.matchFlagB;
			end
			ADDR_STATUS: v[2:0] = {s.matchBlock, s.waveB, s.waveA};
			default: v = '0;
		endcase
		return v;
	endfunction

	// Offsets that answer OKAY; everything else is refused
	function automatic logic isMapped(input logic [7:0] addr);
		logic hit;
		hit = 1'b0;
		unique case (addr)
			ADDR_CTRL: hit = 1'b1;
			ADDR_COUNT: hit = 1'b1;
			ADDR_CMPA: hit = 1'b1;
			ADDR_CMPB: hit = 1'b1;
			ADDR_FLAGS: hit = 1'b1;
			ADDR_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Next internal output state of one compare channel at a tick
	function automatic logic waveNext(input logic cur, input logic [1:0] com,
		input logic canToggle, input logic pwm, input logic match,
		input logic wrapNow, input logic cmpIsTop);
		logic v;
		v = cur;
		// Non-PWM: the output mode picks set, clear or toggle on a match
		if (!pwm) begin
			if (match) begin
				unique case (com)
					2'h0: v = cur;
					2'h1: v = ~cur;
					2'h2: v = 1'b0;
					2'h3: v = 1'b1;
				endcase
			end
		end else if (com[1]) begin
			// Match at top is ignored so the bottom action wins
			if (match && !cmpIsTop) begin
				v = com[0];
			end
			// Bottom action as the count returns to zero
			if (wrapNow) begin
				v = ~com[0];
			end
		end else if (com[0] && canToggle && match) begin
			// Toggle option exists only with the high mode bit
			v = ~cur;
		end
		// Anything else holds the state, output mode zero included
		return v;
	endfunction

	// Port override; toggle code connects in PWM only where allowed
	function automatic logic connected(input logic [1:0] com,
		input logic canToggle, input logic pwm);
		logic on;
		on = 1'b0;
		if (com[1]) begin
			on = 1'b1;
		end else if (com[0]) begin
			on = !pwm || canToggle;
		end
		return on;
	endfunction

	// Mode decode; unknown codes fall through to normal counting
	always_comb begin
		isClear = 1'b0;
		isPwm = 1'b0;
		topValue = COUNT_MAX;
		unique case (q.waveModeSel)
			MODE_CLEAR_ON_MATCH: begin
				isClear = 1'b1;
			end
			MODE_PWM_MAXTOP: begin
				isPwm = 1'b1;
			end
			MODE_PWM_CMPTOP: begin
				isPwm = 1'b1;
				topValue = q.compareValueA;
			end
			default: begin
				isClear = 1'b0;
			end
		endcase
	end

	// Tick divider enable; tickDiv of zero ticks every clock
	// Stopped timer never ticks; a count write still blocks
	assign tick = q.run && q.divCnt == q.tickDiv;

	// Equality seen at a tick acts then, one tick after the count got there
	assign matchA = q.countValue == q.compareValueA && !q.matchBlock;
	assign matchB = q.countValue == q.compareValueB && !q.matchBlock;

	// Period end exists in PWM only; other modes wrap by overflow
	assign atTop = q.countValue == topValue;
	assign wrap = isPwm && atTop;

	// Bus write merge under byte strobes
	assign doWrite = q.awHave && q.wHave && !q.bvalid;
	assign oldWord = readWord(q, q.awAddr);
	assign newWord = (oldWord & ~byteMask) | (q.wData & byteMask);
	assign clrBits = q.wData & byteMask;

	// Byte strobes widened to a bit mask, one lane per strobe
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			byteMask[8 * i +: 8] = {8{q.wStrb[i]}};
		end
	end

	// Whole next-state computation
	always_comb begin
		d = q;

		// Address and data are taken independently, one write at a time
		if (axiReq.awvalid && !q.awHave && !q.bvalid) begin
			d.awHave = 1'b1;
			d.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && !q.wHave && !q.bvalid) begin
			d.wHave = 1'b1;
			d.wData = axiReq.wdata;
			d.wStrb = axiReq.wstrb;
		end
		if (q.bvalid && axiReq.bready) begin
			d.bvalid = 1'b0;
		end
		// Both halves held: apply now, answer from the next cycle
		if (doWrite) begin
			d.awHave = 1'b0;
			d.wHave = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = isMapped(q.awAddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Read answer holds until rready
		if (q.rvalid && axiReq.rready) begin
			d.rvalid = 1'b0;
		end
		// Read data captured at the edge that takes the address
		if (axiReq.arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata = readWord(q, axiReq.araddr);
			d.rresp = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Prescale divider
		if (q.run) begin
			d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
		end else begin
			d.divCnt = 8'h00;
		end

		// Flag clears first so a same-cycle hardware set wins
		if (doWrite && q.awAddr == ADDR_FLAGS) begin
			// Zeros written leave the flags alone
			if (clrBits[FLAG_OVF_BIT]) begin
				d.overflowFlag = 1'b0;
			end
			if (clrBits[FLAG_MATCHA_BIT]) begin
				d.matchFlagA = 1'b0;
			end
			if (clrBits[FLAG_MATCHB_BIT]) begin
				d.matchFlagB = 1'b0;
			end
		end

		// Counting sequence depends on wave mode only, never on output modes
		if (tick) begin
			if (wrap) begin
				d.countValue = COUNT_BOTTOM;
			end else if (isClear && matchA) begin
				d.countValue = COUNT_BOTTOM;
			end else begin
				d.countValue = q.countValue + 8'h01;
			end

			// Overflow as the count leaves 0xff, or leaves top in PWM
			if (isPwm ? atTop : q.countValue == COUNT_MAX) begin
				d.overflowFlag = 1'b1;
			end

			// Match flags; a same-cycle set beats the clear above
			if (matchA) begin
				d.matchFlagA = 1'b1;
			end
			if (matchB) begin
				d.matchFlagB = 1'b1;
			end

			// Output state per channel; only A may toggle in PWM
			d.waveA = waveNext(q.waveA, q.compareOutModeA,
				q.waveModeSel[2], isPwm, matchA, wrap,
				q.compareValueA == topValue);
			d.waveB = waveNext(q.waveB, q.compareOutModeB, 1'b0, isPwm,
				matchB, wrap, q.compareValueB == topValue);
			// Buffered compare values load at the period boundary
			if (wrap) begin
				d.compareValueA = q.compareBufA;
				d.compareValueB = q.compareBufB;
			end
			// A blocked match lasts a single tick
			d.matchBlock = 1'b0;
		end

		// Software writes override counting
		if (doWrite) begin
			unique case (q.awAddr)
				// Output mode changes act from the next match, or from the next bottom in PWM
				ADDR_CTRL: begin
					d.waveModeSel = newWord[CTRL_MODE_LSB +: 3];
					d.compareOutModeB = newWord[CTRL_COMB_LSB +: 2];
					d.compareOutModeA = newWord[CTRL_COMA_LSB +: 2];
					d.dirA = newWord[CTRL_DIRA_BIT];
					d.dirB = newWord[CTRL_DIRB_BIT];
					d.run = newWord[CTRL_RUN_BIT];
					d.tickDiv = newWord[CTRL_DIV_LSB +: 8];
				end
				// Count write beats the tick and blocks the next match
				ADDR_COUNT: begin
					d.countValue = newWord[7:0];
					d.matchBlock = 1'b1;
				end
				// Direct load outside PWM; in PWM the buffer waits
				ADDR_CMPA: begin
					d.compareBufA = newWord[7:0];
					if (!isPwm) begin
						d.compareValueA = newWord[7:0];
					end
				end
				ADDR_CMPB: begin
					d.compareBufB = newWord[7:0];
					if (!isPwm) begin
						d.compareValueB = newWord[7:0];
					end
				end
				default: d.matchBlock = d.matchBlock;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// Bus answers; ready is low while a previous answer is pending
	always_comb begin
		// Write channels
		axiRsp.awready = !q.awHave && !q.bvalid;
		axiRsp.wready = !q.wHave && !q.bvalid;
		axiRsp.bvalid = q.bvalid;
		axiRsp.bresp = q.bresp;

		// Read channel
		axiRsp.arready = !q.rvalid;
		axiRsp.rvalid = q.rvalid;
		axiRsp.rdata = q.rdata;
		axiRsp.rresp = q.rresp;
	end

	// Internal output state, kept while the pin is released
	assign waveOutA = q.waveA;
	assign waveOutB = q.waveB;

	// Pin drive needs both an override mode and the output direction
	assign waveOutAOeN = !(q.dirA && connected(q.compareOutModeA,
		q.waveModeSel[2], isPwm));
	assign waveOutBOeN = !(q.dirB && connected(q.compareOutModeB,
		1'b0, isPwm));

endmodule

`default_nettype wire

// ===== tmw_timer_sva.sv
// Port checks for the timer register bus and pin enables
`timescale 1ns/1ns
`default_nettype none
module tmw_timer_sva (
	input wire logic core_clk,
	input wire logic reset,
	input wire tmw_pkg::tmw_axi_req_type axiReq,
	input wire tmw_pkg::tmw_axi_rsp_type axiRsp,
	input wire logic waveOutA,
	input wire logic waveOutAOeN,
	input wire logic waveOutB,
	input wire logic waveOutBOeN
);
	import tmw_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Answers leave once taken
	write_done_a: assert property (axiRsp.bvalid && axiReq.bready
		|=> !axiRsp.bvalid) else $error("write answer stayed");
	read_done_a: assert property (axiRsp.rvalid && axiReq.rready
		|=> !axiRsp.rvalid) else $error("read answer stayed");
	// One transfer of each kind in flight
	write_block_a: assert property (axiRsp.bvalid
		|-> !axiRsp.awready && !axiRsp.wready) else $error("write open");
	read_block_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("read open");
	// Answer timing from the hand-over
	write_answer_a: assert property (axiReq.awvalid && axiRsp.awready
		&& axiReq.wvalid && axiRsp.wready |=> ##1 axiRsp.bvalid)
		else $error("write answer late");
	read_answer_a: assert property (axiReq.arvalid && axiRsp.arready
		|=> axiRsp.rvalid) else $error("read answer late");
	// Refused reads return zero
	error_data_a: assert property (axiRsp.rvalid
		&& axiRsp.rresp == RESP_SLVERR |-> axiRsp.rdata == 32'h0)
		else $error("refused read gave data");
	// Enables follow register writes only
	enable_a_a: assert property ($changed(waveOutAOeN)
		|-> $rose(axiRsp.bvalid)) else $error("enable a moved alone");
	enable_b_a: assert property ($changed(waveOutBOeN)
		|-> $rose(axiRsp.bvalid)) else $error("enable b moved alone");
endmodule
`default_nettype wire

// ===== tmw_timer_bench.sv
// Self-checking bench: bus tasks and a table of wave modes
`timescale 1ns/1ns
`default_nettype none
module tmw_timer_bench;
	import tmw_pkg::*;
	typedef struct packed {
		logic [2:0] mode; logic [1:0] com; logic [7:0] cmp;
		logic [10:0] hi; logic [8:0] tog; logic oeA; logic oeB;
		logic [2:0] flg;
	} tmw_case_type;
	// Expected pin figures over 1024 ticks; hi 7ff means unknown
	tmw_case_type cases [10] = '{
		'{3'h0, 2'h1, 8'h10, 11'h200, 9'h4, 1'b0, 1'b0, 3'h7},
		'{3'h4, 2'h1, 8'h10, 11'h200, 9'h4, 1'b0, 1'b0, 3'h7},
		'{3'h2, 2'h1, 8'h03, 11'h200, 9'h100, 1'b0, 1'b0, 3'h6},
		'{3'h3, 2'h2, 8'h80, 11'h204, 9'h8, 1'b0, 1'b0, 3'h7},
		'{3'h3, 2'h3, 8'h80, 11'h1fc, 9'h8, 1'b0, 1'b0, 3'h7},
		'{3'h3, 2'h2, 8'h00, 11'h4, 9'h8, 1'b0, 1'b0, 3'h7},
		'{3'h3, 2'h2, 8'hff, 11'h400, 9'h0, 1'b0, 1'b0, 3'h7},
		'{3'h7, 2'h1, 8'h03, 11'h200, 9'h100, 1'b0, 1'b1, 3'h7},
		'{3'h3, 2'h1, 8'h03, 11'h7ff, 9'h0, 1'b1, 1'b1, 3'h7},
		'{3'h2, 2'h0, 8'h03, 11'h7ff, 9'h0, 1'b1, 1'b1, 3'h6}};
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	tmw_axi_req_type axiReq;
	tmw_axi_rsp_type axiRsp;
	logic waveOutA, waveOutAOeN, waveOutB, waveOutBOeN;
	int n_fail = 0;
	int checks_done = 0;
	tmw_timer tmw_timer_i (.core_clk(core_clk), .reset(reset),
		.axiReq(axiReq), .axiRsp(axiRsp), .waveOutA(waveOutA),
		.waveOutAOeN(waveOutAOeN), .waveOutB(waveOutB),
		.waveOutBOeN(waveOutBOeN));
	initial forever #2 core_clk = ~core_clk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Each half released when taken; answer awaited under a bound
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		axiReq.awaddr <= a;
		axiReq.awvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wvalid <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge core_clk);
			if (aw && axiRsp.awready === 1'b1) begin
				aw = 1'b0;
				axiReq.awvalid <= 1'b0;
			end
			if (w && axiRsp.wready === 1'b1) begin
				w = 1'b0;
				axiReq.wvalid <= 1'b0;
			end
			if (axiRsp.bvalid === 1'b1) begin
				r = axiRsp.bresp;
				return;
			end
		end
		n_fail++;
		final_report();
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge core_clk);
			if (axiRsp.arready === 1'b1) begin
				axiReq.arvalid <= 1'b0;
			end
			if (axiRsp.rvalid === 1'b1) begin
				d = axiRsp.rdata;
				r = axiRsp.rresp;
				return;
			end
		end
		n_fail++;
		final_report();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axiWrite(a, d, r);
		check("write answer", r, RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string what);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		check(what, d, e);
	endtask
	// Main sequence: reset values, mode table, stopped count write
	initial begin
		tmw_case_type c;
		int hi, tog, togB;
		logic prev, prevB;
		logic [31:0] d;
		logic [1:0] r;
		axiReq = '0;
		axiReq.wstrb = 4'hf;
		axiReq.bready = 1'b1;
		axiReq.rready = 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rd(ADDR_CTRL, 32'h0, "control");
		rd(ADDR_FLAGS, 32'h0, "flags");
		foreach (cases[i]) begin
			c = cases[i];
			wr(ADDR_CMPA, {24'h0, c.cmp});
			wr(ADDR_CMPB, {24'h0, c.cmp});
			wr(ADDR_CTRL, {21'h0, 3'h7, c.com, c.com, 1'b0, c.mode});
			// Long settle so buffered compare values have loaded
			repeat (600) @(posedge core_clk);
			hi = 0;
			tog = 0;
			togB = 0;
			prev = waveOutA;
			prevB = waveOutB;
			repeat (1024) begin
				@(posedge core_clk);
				if (waveOutA !== prev) tog++;
				if (waveOutB !== prevB) togB++;
				if (waveOutA === 1'b1) hi++;
				prev = waveOutA;
				prevB = waveOutB;
			end
			if (c.hi != 11'h7ff) check("high time", hi, c.hi);
			check("toggles", tog, c.tog);
			check("toggles b", togB,
				c.mode == MODE_PWM_CMPTOP ? 32'h0 : 32'(c.tog));
			check("enable a", waveOutAOeN, c.oeA);
			check("enable b", waveOutBOeN, c.oeB);
			wr(ADDR_FLAGS, 32'h7);
			repeat (300) @(posedge core_clk);
			rd(ADDR_FLAGS, {29'h0, c.flg}, "flags");
		end
		// Clear-on-match with the count above top, then a blocked match
		wr(ADDR_COUNT, 32'h10);
		wr(ADDR_FLAGS, 32'h7);
		rd(ADDR_FLAGS, 32'h0, "flags above top");
		wr(ADDR_COUNT, 32'h3);
		rd(ADDR_FLAGS, 32'h0, "flags blocked");
		repeat (300) @(posedge core_clk);
		rd(ADDR_FLAGS, 32'h7, "flags after wrap");
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_COUNT, 32'h5a);
		rd(ADDR_COUNT, 32'h5a, "count");
		axiRead(ADDR_STATUS, d, r);
		check("match block", d & 32'h4, 32'h4);
		axiWrite(8'h18, 32'h1, r);
		check("unmapped write", r, RESP_SLVERR);
		axiRead(8'h18, d, r);
		check("unmapped read", r, RESP_SLVERR);
		final_report();
	end
endmodule
bind tmw_timer tmw_timer_sva tmw_timer_sva_i (.core_clk(core_clk),
	.reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
	.waveOutA(waveOutA), .waveOutAOeN(waveOutAOeN),
	.waveOutB(waveOutB), .waveOutBOeN(waveOutBOeN));
`default_nettype wire
